// file: include/ccms_cfg.svh
// constants for the cpu clock mode select block
`ifndef CCMS_CFG_SVH
`define CCMS_CFG_SVH
`define CCMS_CFG_MSB 7
`define CCMS_CFG_LSB 5
`define CCMS_RCFG_RESET 8'hFF
`define CCMS_CODE_X4 3'h7
`define CCMS_CODE_X3 3'h6
`define CCMS_CODE_X2 3'h5
`define CCMS_CODE_X5 3'h4
`define CCMS_CODE_DIRECT 3'h3
`define CCMS_CODE_X1P5 3'h2
`define CCMS_CODE_DIV2 3'h1
`define CCMS_CODE_X2P5 3'h0
`define CCMS_PHASE_BITS 5
`endif

// file: include/ccms_pkg.sv
// types for the cpu clock mode select block
package ccms_pkg;
  typedef enum logic [2:0] {
    CCMS_MODE_PRESCALE = 3'h1,
    CCMS_MODE_DIRECT = 3'h2,
    CCMS_MODE_PLL = 3'h4
  } ccms_mode_t;
  typedef struct packed {
    ccms_mode_t mode;
    logic [3:0] mul_half;
    logic pll_en;
  } ccms_sel_t;
endpackage : ccms_pkg

// file: src/ccms_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module ccms_sync3 #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] next_q;
  always_comb begin
    next_q = q_o;
    for (int i = 0; i < W; i++) begin
      // s1 feeds only s2; accept a change once s2 and s3 agree
      if (s2[i] == s3[i]) begin
        next_q[i] = s2[i];
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q_o <= '0;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      q_o <= next_q;
    end
  end
endmodule : ccms_sync3

// file: src/ccms_top.sv
// cpu clock mode select: field capture, mode decode and cpu clock phase generation
`timescale 1ns/1ps
`include "ccms_cfg.svh"
module ccms_top
  import ccms_pkg::*;
#(
  parameter int PHASE_BITS = `CCMS_PHASE_BITS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // reset and reload control
  input wire logic long_reset_i,
  input wire logic reload_i,
  input wire logic [7:0] port_zero_upper_byte_i,
  input wire logic [15:0] reset_control_reg_i,
  // oscillator sampled on clk_i
  input wire logic osc_i,
  // outputs
  output logic [7:0] reset_config_high_o,
  output logic [2:0] clock_source_field_o,
  output logic [2:0] mode_o,
  output logic pll_en_o,
  output logic cpu_clk_o,
  output logic phase_edge_o
);
  logic [7:0] p0_sync;
  logic osc_sync;
  logic [7:0] rcfg;
  logic [7:0] next_rcfg;
  logic osc_d;
  logic [3:0] trans_cnt;
  logic [3:0] next_trans_cnt;
  logic [PHASE_BITS-1:0] per_cnt;
  logic [PHASE_BITS-1:0] next_per_cnt;
  logic [PHASE_BITS-1:0] in_period;
  logic [PHASE_BITS-1:0] next_in_period;
  logic [PHASE_BITS-1:0] meas;
  logic [PHASE_BITS-1:0] next_meas;
  logic [PHASE_BITS+3:0] acc;
  logic [PHASE_BITS+3:0] next_acc;
  logic cpu_clk;
  logic next_cpu_clk;
  logic edge_q;
  logic next_edge;
  ccms_sel_t sel;
  logic osc_edge;

  // decode used by the clock path and the mode outputs
  function automatic ccms_sel_t decode(input logic [2:0] f);
    ccms_sel_t s;
    s.mode = CCMS_MODE_PLL;
    s.pll_en = 1'b1;
    case (f)
      `CCMS_CODE_X4: s.mul_half = 4'h8;
      `CCMS_CODE_X3: s.mul_half = 4'h6;
      `CCMS_CODE_X2: s.mul_half = 4'h4;
      `CCMS_CODE_X5: s.mul_half = 4'hA;
      `CCMS_CODE_X1P5: s.mul_half = 4'h3;
      `CCMS_CODE_X2P5: s.mul_half = 4'h5;
      `CCMS_CODE_DIRECT: begin
        s.mode = CCMS_MODE_DIRECT;
        s.pll_en = 1'b0;
        s.mul_half = 4'h2;
      end
      `CCMS_CODE_DIV2: begin
        s.mode = CCMS_MODE_PRESCALE;
        s.pll_en = 1'b0;
        s.mul_half = 4'h1;
      end
      default: s.mul_half = 4'h8;
    endcase
    return s;
  endfunction : decode

  ccms_sync3 #(.W(9)) u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .d_i({osc_i, port_zero_upper_byte_i}),
    .q_o({osc_sync, p0_sync})
  );

  assign sel = decode(rcfg[`CCMS_CFG_MSB:`CCMS_CFG_LSB]);
  assign osc_edge = osc_sync ^ osc_d;

  // configuration register
  always_comb begin
    next_rcfg = rcfg;
    if (long_reset_i) begin
      next_rcfg = p0_sync;
    end else if (reload_i) begin
      next_rcfg = reset_control_reg_i[15:8];
    end
  end

  // cpu clock generation; the fast clock limits pll resolution, a trade for a
  // fully synchronous design with no analog loop
  always_comb begin
    next_trans_cnt = trans_cnt;
    next_per_cnt = per_cnt;
    next_in_period = in_period;
    next_acc = acc;
    next_cpu_clk = cpu_clk;
    next_edge = 1'b0;
    next_meas = meas;
    if (per_cnt != {PHASE_BITS{1'b1}}) begin
      next_per_cnt = per_cnt + 1'b1;
    end
    // measured in every mode so a switch into pll mode starts from a fresh period
    if (osc_sync && !osc_d) begin
      next_meas = per_cnt;
      next_per_cnt = {{(PHASE_BITS-1){1'b0}}, 1'b1};
    end
    case (sel.mode)
      CCMS_MODE_DIRECT: begin
        // phases follow input duty, pairs sum to one input period
        next_cpu_clk = osc_sync;
        next_edge = osc_sync ^ cpu_clk;
      end
      CCMS_MODE_PRESCALE: begin
        if (osc_sync && !osc_d) begin
          next_cpu_clk = ~cpu_clk;
          next_edge = 1'b1;
        end
      end
      CCMS_MODE_PLL: begin
        // accumulate 2*F phase steps per input period; counter limits to that rate
        if (osc_edge) begin
          if (trans_cnt + 4'h1 >= sel.mul_half[3:1] || sel.mul_half[3:1] == 3'h0) begin
            next_trans_cnt = 4'h0;
            // every F-th transition (F rounded down) step halfway toward the measured period, rounding
            // toward it so the estimate cannot stall one count away
            next_in_period = PHASE_BITS'(((PHASE_BITS+1)'(in_period) + meas
                + (PHASE_BITS+1)'(meas > in_period)) >> 1);
          end else begin
            next_trans_cnt = trans_cnt + 4'h1;
          end
        end
        next_acc = acc + (PHASE_BITS+4)'(sel.mul_half);
        if (acc + (PHASE_BITS+4)'(sel.mul_half) >= (PHASE_BITS+4)'(in_period)) begin
          next_acc = acc + (PHASE_BITS+4)'(sel.mul_half) - (PHASE_BITS+4)'(in_period);
          next_cpu_clk = ~cpu_clk;
          next_edge = 1'b1;
        end
      end
      default: begin
        next_cpu_clk = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rcfg <= `CCMS_RCFG_RESET;
      osc_d <= 1'b0;
      trans_cnt <= '0;
      per_cnt <= '1;
      meas <= '1;
      in_period <= '1;
      acc <= '0;
      cpu_clk <= 1'b0;
      edge_q <= 1'b0;
      reset_config_high_o <= `CCMS_RCFG_RESET;
      clock_source_field_o <= `CCMS_CODE_X4;
      mode_o <= CCMS_MODE_PLL;
      pll_en_o <= 1'b1;
      cpu_clk_o <= 1'b0;
      phase_edge_o <= 1'b0;
    end else begin
      rcfg <= next_rcfg;
      osc_d <= osc_sync;
      trans_cnt <= next_trans_cnt;
      per_cnt <= next_per_cnt;
      meas <= next_meas;
      in_period <= next_in_period;
      acc <= next_acc;
      cpu_clk <= next_cpu_clk;
      edge_q <= next_edge;
      reset_config_high_o <= rcfg;
      clock_source_field_o <= rcfg[`CCMS_CFG_MSB:`CCMS_CFG_LSB];
      mode_o <= sel.mode;
      pll_en_o <= sel.pll_en;
      cpu_clk_o <= cpu_clk;
      phase_edge_o <= edge_q;
    end
  end
endmodule : ccms_top

// file: tb/ccms_properties.sv
// assertion checker for the cpu clock mode select block
`timescale 1ns/1ps
module ccms_properties (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // control
  input wire logic long_reset_i,
  input wire logic reload_i,
  input wire logic [7:0] port_zero_upper_byte_i,
  input wire logic [15:0] reset_control_reg_i,
  // outputs
  input wire logic [7:0] reset_config_high_o,
  input wire logic [2:0] clock_source_field_o,
  input wire logic [2:0] mode_o,
  input wire logic pll_en_o,
  input wire logic cpu_clk_o,
  input wire logic phase_edge_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_reload;
    reload_i && !long_reset_i;
  endsequence
  sequence s_capture;
    (long_reset_i && $stable(port_zero_upper_byte_i)) [*8];
  endsequence
  a_field_mirror: assert property (clock_source_field_o == reset_config_high_o[7:5])
    else $error("field differs from config bits");
  a_reload_load: assert property (s_reload |-> ##2 reset_config_high_o == $past(reset_control_reg_i[15:8], 2))
    else $error("reload value not taken");
  a_config_hold: assert property ($changed(reset_config_high_o) |-> $past(reload_i || long_reset_i, 2))
    else $error("config changed without a load");
  a_long_capture: assert property (s_capture |-> reset_config_high_o == port_zero_upper_byte_i)
    else $error("pins not captured");
  a_mode_decode: assert property (mode_o == ((clock_source_field_o == 3'h3) ? 3'h2 : (clock_source_field_o == 3'h1) ? 3'h1 : 3'h4))
    else $error("mode decode wrong");
  a_pll_enable: assert property (pll_en_o == (mode_o == 3'h4))
    else $error("pll enable wrong");
  a_edge_pulse: assert property ($changed(cpu_clk_o) == phase_edge_o)
    else $error("edge pulse not tied to clock toggle");
  a_reset_value: assert property ($fell(srst_i) |-> reset_config_high_o == 8'hFF && mode_o == 3'h4)
    else $error("reset defaults wrong");
endmodule : ccms_properties
bind ccms_top ccms_properties u_chk (.clk_i(clk_i), .srst_i(srst_i), .long_reset_i(long_reset_i),
  .reload_i(reload_i), .port_zero_upper_byte_i(port_zero_upper_byte_i),
  .reset_control_reg_i(reset_control_reg_i), .reset_config_high_o(reset_config_high_o),
  .clock_source_field_o(clock_source_field_o), .mode_o(mode_o), .pll_en_o(pll_en_o),
  .cpu_clk_o(cpu_clk_o), .phase_edge_o(phase_edge_o));

// file: tb/ccms_osc_model.sv
// free-running oscillator with settable high and low times
`timescale 1ns/1ps
module ccms_osc_model (
  // reference and shape, in clock cycles, never zero
  input wire logic clk_i,
  input wire logic [3:0] hi_i,
  input wire logic [3:0] lo_i,
  // oscillator level
  output logic osc_o
);
  initial osc_o = 1'b0;
  // uneven hi and lo give a skewed duty cycle
  // one fixed wait per phase keeps time moving while the shape inputs are still unknown
  always begin
    @(negedge clk_i);
    repeat (lo_i - 4'h1) @(negedge clk_i);
    osc_o = 1'b1;
    @(negedge clk_i);
    repeat (hi_i - 4'h1) @(negedge clk_i);
    osc_o = 1'b0;
  end
endmodule : ccms_osc_model

// file: tb/ccms_top_tb.sv
// self-checking bench for the cpu clock mode select block
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; $display("CHECK FAILED %0t mismatch", $time); end end
module ccms_top_tb;
  logic clk_i = 0, srst_i = 1, long_reset_i = 0, reload_i = 0, osc_i, pll, cpu, edge_p;
  logic [7:0] pins = 8'h00, cfg;
  logic [15:0] rst_ctl = 16'h0000;
  logic [3:0] hi = 4'h4, lo = 4'h4;
  logic [2:0] fld, mode;
  int err_total = 0, compares = 0, cyc = 0;
  always #20 clk_i = ~clk_i;
  ccms_osc_model OSC (.clk_i(clk_i), .hi_i(hi), .lo_i(lo), .osc_o(osc_i));
  ccms_top DUT (.clk_i(clk_i), .srst_i(srst_i), .long_reset_i(long_reset_i), .reload_i(reload_i),
    .port_zero_upper_byte_i(pins), .reset_control_reg_i(rst_ctl), .osc_i(osc_i),
    .reset_config_high_o(cfg), .clock_source_field_o(fld), .mode_o(mode), .pll_en_o(pll),
    .cpu_clk_o(cpu), .phase_edge_o(edge_p));
  task automatic results();
    if (err_total == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task automatic cfg_check(input logic [2:0] c);
    `CHK(fld, c)
    `CHK(mode, c == 3'h3 ? 3'h2 : c == 3'h1 ? 3'h1 : 3'h4)
    `CHK(pll, c != 3'h3 && c != 3'h1)
  endtask : cfg_check
  // reload is held off while long reset is up, so the pins must win
  task automatic t_capture();
    pins = 8'hA5;
    long_reset_i = 1;
    reload_i = 1;
    rst_ctl = 16'h3300;
    repeat (10) @(negedge clk_i);
    long_reset_i = 0;
    reload_i = 0;
    repeat (3) @(negedge clk_i);
    pins = 8'h1F;
    repeat (8) @(negedge clk_i);
    `CHK(cfg, 8'hA5)
    cfg_check(3'h5);
  endtask : t_capture
  task automatic t_reload();
    for (int c = 0; c < 8; c++) begin
      rst_ctl = {c[2:0], 5'h15, 8'hC3};
      reload_i = 1;
      @(negedge clk_i);
      reload_i = 0;
      repeat (2) @(negedge clk_i);
      `CHK(cfg, {c[2:0], 5'h15})
      cfg_check(c[2:0]);
    end
  endtask : t_reload
  // counts both cpu clock edges over 40 oscillator periods of 8 cycles
  task automatic t_rate(input logic [2:0] c, input logic [3:0] h, input logic [3:0] l, input int n);
    int k;
    int t;
    int run;
    int prev_run;
    logic last;
    hi = h;
    lo = l;
    rst_ctl = {c, 13'h0};
    reload_i = 1;
    @(negedge clk_i);
    reload_i = 0;
    repeat (40) @(negedge clk_i);
    k = 0;
    t = 0;
    run = 0;
    prev_run = 0;
    last = cpu;
    repeat (320) begin
      @(negedge clk_i);
      k += edge_p;
      run++;
      if (cpu !== last) begin
        t++;
        if (t >= 3 && c == 3'h1) `CHK(run, h + l)
        if (t >= 3 && c == 3'h3) `CHK(run + prev_run, h + l)
        prev_run = run;
        run = 0;
        last = cpu;
      end
    end
    `CHK(k >= n - 3 && k <= n + 3, 1'b1)
    `CHK(t >= n - 3 && t <= n + 3, 1'b1)
  endtask : t_rate
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      results();
    end
  end
  initial begin
    repeat (10) @(negedge clk_i);
    srst_i = 0;
    @(negedge clk_i);
    `CHK(cfg, 8'hFF)
    cfg_check(3'h7);
    t_capture();
    t_reload();
    t_rate(3'h1, 4'h4, 4'h4, 40);
    t_rate(3'h3, 4'h3, 4'h5, 80);
    t_rate(3'h5, 4'h4, 4'h4, 160);
    t_rate(3'h0, 4'h4, 4'h4, 200);
    results();
  end
endmodule : ccms_top_tb
